//--- verilog/cms_call_mode_ctrl.sv
// Call mode and stack select register with call timing sequencer
//
// Summary of operation
// - Bit 3 set means short stack mode.
// - Stack area field 0 is bank 0.
// - Calls push two or three stack bytes.
// - Calls take one extra cycle in extended.
// - Far branch and call need extended mode.
// - Register written by 4-bit memory instruction.
// - Reset sets mode bit, short stack mode.
// - Register decodes at data address F84H.
`timescale 1ns/1ns
module cms_call_mode_ctrl
	import cms_pkg::*;
(
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  arst_n,
	// Data memory access from the CPU
	input  wire logic [CMS_ADDR_W-1:0] mem_addr,
	input  wire logic                  mem_wr,
	input  wire logic                  mem_rd,
	input  wire logic [CMS_DATA_W-1:0] mem_wdata,
	output logic      [CMS_DATA_W-1:0] mem_rdata,
	output logic                       mem_rvalid,
	// Operation request from the instruction decoder
	input  wire logic                  op_start,
	input  wire logic [2:0]            op_kind,
	input  wire logic                  mc_tick,
	// Operation progress
	output logic                       op_busy,
	output logic                       op_done,
	output logic                       op_illegal,
	output logic                       stack_push,
	output logic [2:0]                 op_cycles,
	output logic [1:0]                 op_bytes,
	// Mode and stack status
	output logic                       short_stack_mode,
	output logic [3:0]                 stack_bank,
	output logic                       stack_area_fault
);

	logic [CMS_DATA_W-1:0] call_mode_stack_select;
	logic                  reg_hit;
	logic                  reg_write;
	logic                  mode_now;
	logic                  dec_legal;
	logic [2:0]            dec_cycles;
	logic [1:0]            dec_bytes;
	cms_state_t            state;
	logic [2:0]            cyc_left;
	logic [1:0]            bytes_left;

	// Address decode for the single register
	always_comb
	begin
		if (mem_addr == CMS_REG_ADDR)
		begin
			reg_hit = 1'b1;
		end
		else
		begin
			reg_hit = 1'b0;
		end
	end

	assign reg_write = reg_hit & mem_wr;

	// A write in the same cycle as a request steers that request
	assign mode_now = reg_write ? mem_wdata[CMS_MODE_BIT]
		: call_mode_stack_select[CMS_MODE_BIT];

	// Register storage; bit 2 is stored as written so software sees its own value
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			call_mode_stack_select <= CMS_RESET_VAL;
		end
		else if (reg_write)
		begin
			call_mode_stack_select <= mem_wdata;
		end
	end

	// Registered read path
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mem_rdata  <= 4'h0;
			mem_rvalid <= 1'b0;
		end
		else
		begin
			mem_rvalid <= mem_rd & reg_hit;
			if (mem_rd && reg_hit)
			begin
				mem_rdata <= call_mode_stack_select;
			end
			else
			begin
				mem_rdata <= 4'h0;
			end
		end
	end

	// Mode and stack bank outputs
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			short_stack_mode <= CMS_RESET_VAL[CMS_MODE_BIT];
			stack_bank       <= CMS_STACK_BANK;
		end
		else
		begin
			short_stack_mode <= mode_now;
			// Only bank 0 exists for the stack; other field values are not honoured
			stack_bank       <= CMS_STACK_BANK;
		end
	end

	// Prohibited stack area field, also flags a set reserved bit
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stack_area_fault <= 1'b0;
		end
		else if (reg_write)
		begin
			stack_area_fault <= (mem_wdata[CMS_AREA_MSB:CMS_AREA_LSB] != CMS_AREA_BANK0)
				| mem_wdata[CMS_RSVD_BIT];
		end
	end

	cms_op_decode u_decode (
		.short_mode (mode_now),
		.op_kind    (op_kind),
		.legal      (dec_legal),
		.cycles     (dec_cycles),
		.bytes      (dec_bytes)
	);

	// Operation sequencer; requests while busy are ignored
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state      <= CMS_ST_IDLE;
			cyc_left   <= 3'h0;
			bytes_left <= 2'h0;
		end
		else
		begin
			case (state)
				CMS_ST_IDLE:
				begin
					if (op_start && dec_legal)
					begin
						state      <= CMS_ST_RUN;
						cyc_left   <= dec_cycles;
						bytes_left <= dec_bytes;
					end
				end
				CMS_ST_RUN:
				begin
					if (mc_tick)
					begin
						if (bytes_left != 2'h0)
						begin
							bytes_left <= 2'(bytes_left - 2'h1);
						end
						cyc_left <= 3'(cyc_left - 3'h1);
						if (cyc_left == 3'h1)
						begin
							state <= CMS_ST_IDLE;
						end
					end
				end
				default:
				begin
					state <= CMS_ST_IDLE;
				end
			endcase
		end
	end

	// Pulses and status of the sequencer
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			op_busy    <= 1'b0;
			op_done    <= 1'b0;
			op_illegal <= 1'b0;
			stack_push <= 1'b0;
		end
		else
		begin
			op_illegal <= (state == CMS_ST_IDLE) & op_start & ~dec_legal;
			stack_push <= (state == CMS_ST_RUN) & mc_tick & (bytes_left != 2'h0);
			op_done    <= (state == CMS_ST_RUN) & mc_tick & (cyc_left == 3'h1);
			if (state == CMS_ST_IDLE)
			begin
				op_busy <= op_start & dec_legal;
			end
			else if (mc_tick && cyc_left == 3'h1)
			begin
				op_busy <= 1'b0;
			end
		end
	end

	// Cycle and byte figures of the last accepted operation
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			op_cycles <= 3'h0;
			op_bytes  <= 2'h0;
		end
		else if (state == CMS_ST_IDLE && op_start && dec_legal)
		begin
			op_cycles <= dec_cycles;
			op_bytes  <= dec_bytes;
		end
	end

endmodule // cms_call_mode_ctrl

//--- include/cms_pkg.sv
// Constants and types for the call mode and stack select block
package cms_pkg;

	// Data memory access
	localparam int          CMS_ADDR_W      = 12;
	localparam int          CMS_DATA_W      = 4;
	localparam logic [11:0] CMS_REG_ADDR    = 12'hf84;

	// Field positions of call_mode_stack_select
	localparam int          CMS_MODE_BIT    = 3;
	localparam int          CMS_RSVD_BIT    = 2;
	localparam int          CMS_AREA_MSB    = 1;
	localparam int          CMS_AREA_LSB    = 0;

	// Reset value: legacy_mode_bit set, stack in bank 0
	localparam logic [3:0]  CMS_RESET_VAL   = 4'h8;
	localparam logic [1:0]  CMS_AREA_BANK0  = 2'h0;
	localparam logic [3:0]  CMS_STACK_BANK  = 4'h0;

	// Machine cycle counts
	localparam logic [2:0]  CMS_ABS_CYC     = 3'h3;
	localparam logic [2:0]  CMS_FIX_CYC     = 3'h2;
	localparam logic [2:0]  CMS_EXT_CYC_ADD = 3'h1;
	localparam logic [2:0]  CMS_FAR_BR_CYC  = 3'h3;
	localparam logic [2:0]  CMS_FAR_CALL_CYC = 3'h4;
	localparam logic [2:0]  CMS_INT_CYC     = 3'h3;

	// Stack bytes per call
	localparam logic [1:0]  CMS_BYTES_SHORT = 2'h2;
	localparam logic [1:0]  CMS_BYTES_EXT   = 2'h3;
	localparam logic [1:0]  CMS_BYTES_NONE  = 2'h0;

	// Operations the sequencer times
	typedef enum logic [2:0] {
		CMS_OP_ABS_CALL = 3'b000,
		CMS_OP_FIX_CALL = 3'b001,
		CMS_OP_FAR_BR   = 3'b010,
		CMS_OP_FAR_CALL = 3'b011,
		CMS_OP_INTR     = 3'b100
	} cms_op_t;

	typedef enum logic [1:0] {
		CMS_ST_IDLE = 2'b00,
		CMS_ST_RUN  = 2'b01
	} cms_state_t;

endpackage

//--- verilog/cms_op_decode.sv
// Mode dependent decode of cycle count, stack bytes and legality
`timescale 1ns/1ns
module cms_op_decode
	import cms_pkg::*;
(
	// Mode and operation
	input  wire logic       short_mode,
	input  wire logic [2:0] op_kind,
	// Decode result
	output logic            legal,
	output logic [2:0]      cycles,
	output logic [1:0]      bytes
);

	function automatic logic [5:0] decode_op(input logic short_m, input logic [2:0] kind);
		logic       ok;
		logic [2:0] cyc;
		logic [1:0] byt;
		ok  = 1'b1;
		cyc = CMS_ABS_CYC;
		byt = short_m ? CMS_BYTES_SHORT : CMS_BYTES_EXT;
		case (kind)
			CMS_OP_ABS_CALL: cyc = short_m ? CMS_ABS_CYC : 3'(CMS_ABS_CYC + CMS_EXT_CYC_ADD);
			CMS_OP_FIX_CALL: cyc = short_m ? CMS_FIX_CYC : 3'(CMS_FIX_CYC + CMS_EXT_CYC_ADD);
			CMS_OP_FAR_BR:
			begin
				ok  = ~short_m;
				cyc = CMS_FAR_BR_CYC;
				byt = CMS_BYTES_NONE;
			end
			CMS_OP_FAR_CALL:
			begin
				ok  = ~short_m;
				cyc = CMS_FAR_CALL_CYC;
			end
			CMS_OP_INTR:     cyc = CMS_INT_CYC;
			default:         ok  = 1'b0;
		endcase
		return {ok, cyc, byt};
	endfunction

	always_comb
	begin
		{legal, cycles, bytes} = decode_op(short_mode, op_kind);
	end

endmodule // cms_op_decode

//--- dv/cms_call_mode_ctrl_asserts.sv
// Concurrent checks on the call mode and stack select block
`timescale 1ns/1ns
module cms_call_mode_ctrl_asserts
	import cms_pkg::*;
(
	// Clock, reset, register access
	input wire logic        clock,
	input wire logic        arst_n,
	input wire logic [11:0] mem_addr,
	input wire logic        mem_wr,
	input wire logic        mem_rd,
	input wire logic [3:0]  mem_wdata,
	input wire logic [3:0]  mem_rdata,
	input wire logic        mem_rvalid,
	// Operations and mode
	input wire logic        op_start,
	input wire logic [2:0]  op_kind,
	input wire logic        op_busy,
	input wire logic        op_illegal,
	input wire logic [2:0]  op_cycles,
	input wire logic [1:0]  op_bytes,
	input wire logic        short_stack_mode
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	sequence wr_s;
		mem_wr && mem_addr == CMS_REG_ADDR;
	endsequence
	// No write alongside, so the stored mode applies
	sequence acc_s;
		op_start && !op_busy && !mem_wr;
	endsequence

	mode_follow_a: assert property (wr_s |=> short_stack_mode == $past(mem_wdata[3]))
		else $error("mode bit not applied");
	call_bytes_a: assert property (acc_s ##0 op_kind == 3'h0 |=>
		op_bytes == (short_stack_mode ? 2'h2 : 2'h3)) else $error("call bytes");
	call_cycles_a: assert property (acc_s ##0 op_kind == 3'h1 |=>
		op_cycles == (short_stack_mode ? 3'h2 : 3'h3)) else $error("call cycles");
	far_refuse_a: assert property (acc_s ##0 op_kind[2:1] == 2'b01 && short_stack_mode
		|=> op_illegal && !op_busy) else $error("far op not refused");
	reg_readback_a: assert property (wr_s ##1 !mem_wr ##1 mem_rd && !mem_wr &&
		mem_addr == CMS_REG_ADDR |=> mem_rvalid && mem_rdata == $past(mem_wdata, 3))
		else $error("readback wrong");
	reset_mode_a: assert property ($rose(arst_n) |-> short_stack_mode)
		else $error("not short mode after reset");
	addr_decode_a: assert property (mem_rd && mem_addr != CMS_REG_ADDR |=> !mem_rvalid)
		else $error("foreign address answered");
	next_op_a: assert property (wr_s ##0 mem_wdata[3] ##1 !mem_wr ##1 acc_s ##0
		op_kind == 3'h1 |=> op_cycles == 3'h2) else $error("mode change late");
endmodule // cms_call_mode_ctrl_asserts

bind cms_call_mode_ctrl cms_call_mode_ctrl_asserts i_cms_call_mode_ctrl_asserts (.*);

//--- dv/test_cms_call_mode_ctrl.sv
// Bench for the call mode and stack select block
`timescale 1ns/1ns
module test_cms_call_mode_ctrl
	import cms_pkg::*;
;
	logic        clock = 0;
	logic        arst_n = 0;
	logic [11:0] mem_addr = 0;
	logic        mem_wr = 0;
	logic        mem_rd = 0;
	logic [3:0]  mem_wdata = 0;
	logic [3:0]  mem_rdata;
	logic        mem_rvalid;
	logic        op_start = 0;
	logic [2:0]  op_kind = 0;
	logic        mc_tick = 0;
	logic        op_busy;
	logic        op_done;
	logic        op_illegal;
	logic        stack_push;
	logic [2:0]  op_cycles;
	logic [1:0]  op_bytes;
	logic        short_stack_mode;
	logic [3:0]  stack_bank;
	logic        stack_area_fault;
	int          failures = 0;
	int          num_checks = 0;
	int          ticks = 0;

	cms_call_mode_ctrl i_cms_call_mode_ctrl (.*);

	initial
		forever #2 clock = ~clock;

	task automatic report_and_stop;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Generous ceiling, a full run needs about 120 cycles
	always @(posedge clock)
	begin
		ticks <= ticks + 1;
		if (ticks == 3000)
		begin
			failures++;
			report_and_stop;
		end
	end

	task automatic chk(string n, logic [3:0] e, logic [3:0] g);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic wr(logic [11:0] a, logic [3:0] d);
		@(posedge clock);
		mem_addr <= a;
		mem_wdata <= d;
		mem_wr <= 1'b1;
		@(posedge clock);
		mem_wr <= 1'b0;
	endtask

	task automatic rd(logic [11:0] a, logic v, logic [3:0] d);
		@(posedge clock);
		mem_addr <= a;
		mem_rd <= 1'b1;
		@(posedge clock);
		mem_rd <= 1'b0;
		#1;
		chk("rvalid", v, mem_rvalid);
		chk("rdata", d, mem_rdata);
	endtask

	// Ticks every other cycle; pushes and done counted over the run
	task automatic op(logic [2:0] k, logic ill, logic [2:0] c, logic [1:0] b);
		int p = 0;
		int d = 0;
		@(posedge clock);
		op_kind <= k;
		op_start <= 1'b1;
		@(posedge clock);
		op_start <= 1'b0;
		#1;
		chk("illegal", ill, op_illegal);
		if (!ill)
		begin
			chk("cycles", c, op_cycles);
			chk("bytes", b, op_bytes);
			for (int i = 0; i < 2 * c + 2; i++)
			begin
				@(posedge clock);
				mc_tick <= i < 2 * c && !i[0];
				#1;
				p += stack_push;
				d += op_done;
			end
			chk("pushes", b, p[3:0]);
			chk("done", 1, d[3:0]);
			chk("busy", 0, op_busy);
		end
	endtask

	initial
	begin
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		#1;
		chk("mode", 1, short_stack_mode);
		chk("bank", 0, stack_bank);
		rd(CMS_REG_ADDR, 1, 4'h8);
		$display("test reset done");
		op(3'h0, 0, 3, 2);
		op(3'h1, 0, 2, 2);
		op(3'h2, 1, 0, 0);
		op(3'h3, 1, 0, 0);
		op(3'h4, 0, 3, 2);
		$display("test short mode done");
		wr(CMS_REG_ADDR, 4'h0);
		rd(CMS_REG_ADDR, 1, 4'h0);
		chk("mode", 0, short_stack_mode);
		op(3'h0, 0, 4, 3);
		op(3'h1, 0, 3, 3);
		op(3'h2, 0, 3, 0);
		op(3'h3, 0, 4, 3);
		op(3'h4, 0, 3, 3);
		op(3'h5, 1, 0, 0);
		$display("test extended mode done");
		wr(12'hf85, 4'h8);
		rd(12'hf85, 0, 4'h0);
		rd(CMS_REG_ADDR, 1, 4'h0);
		wr(CMS_REG_ADDR, 4'h8);
		op(3'h1, 0, 2, 2);
		$display("test decode and switch done");
		// Area field set, bit 2 still zero
		wr(CMS_REG_ADDR, 4'h9);
		rd(CMS_REG_ADDR, 1, 4'h9);
		chk("fault", 1, stack_area_fault);
		chk("bank", 0, stack_bank);
		wr(CMS_REG_ADDR, 4'h8);
		rd(CMS_REG_ADDR, 1, 4'h8);
		chk("fault", 0, stack_area_fault);
		$display("test stack area fault done");
		report_and_stop;
	end
endmodule // test_cms_call_mode_ctrl
